// file: shared/adc_consts.svh
// Constants for the serial converter pin interface: widths, counts and timing.
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------------
`define RESULT_WIDTH 12
`define CTRL_WIDTH 8
`define FIFO_DEPTH 16

// ----------------------------------------------------------------------------
// Control byte bit positions and serial counts
// ----------------------------------------------------------------------------
`define CTRL_INT_CLK_BIT 0
`define TRACK_START_BIT 4'h5
`define HOLD_BIT 4'h8
`define RESULT_MSB_INDEX 4'hb

// ----------------------------------------------------------------------------
// Shutdown pin levels
// ----------------------------------------------------------------------------
`define SHUTDOWN_LEVEL_IN_LEVEL_LOW 2'h0
`define SHUTDOWN_LEVEL_IN_LEVEL_HIGH 2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MCLK_PERIOD_NS 20
`define CONV_TIME_NS 10000
`define CONV_CYCLES (`CONV_TIME_NS / `MCLK_PERIOD_NS)
`define CONV_TIMER_WIDTH 10

`endif

// file: shared/adc_pkg.sv
// Types shared by the serial converter pin interface.
package adc_pkg;

  // Output side of the serial link.
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_STROBE = 2'b01,
    TX_CONVERT = 2'b10,
    TX_SHIFT = 2'b11
  } tx_state_t;

  // Control byte as it arrives, start bit first.
  typedef struct packed {
    logic start;
    logic [2:0] chan;
    logic [2:0] opts;
    logic int_clk;
  } ctrl_t;

  // Power state derived from the three-level shutdown pin.
  typedef struct packed {
    logic powered_down;
    logic internal_comp;
  } power_t;

endpackage

// file: design/serial_adc_pin_interface.sv
// Pin-level serial interface of an 8-channel 12-bit converter, with its sample FIFO.
`timescale 1ns/1ps
`include "adc_consts.svh"
// ----------------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------------
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic ready_r, ready_nxt, push, pop;
  always_comb begin
    push = in_valid_i & ready_r;
    pop = (count_r != '0) & out_ready_i;
    wr_ptr_nxt = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
    count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    // Registered ready keeps the block's own ready output glitch free.
    ready_nxt = count_nxt < (AW+1)'(DEPTH);
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      ready_r <= ready_nxt;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
  assign in_ready_o = ready_r;
  assign out_valid_o = count_r != '0;
  assign out_data_o = mem_r[rd_ptr_r];
endmodule

// ----------------------------------------------------------------------------
// Serial interface top
// ----------------------------------------------------------------------------
module serial_adc_pin_interface
  import adc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic [1:0] shutdown_level_in_i,
  input wire logic sample_valid_i,
  input wire logic [`RESULT_WIDTH-1:0] sample_data_i,
  output logic sample_ready_o,
  output logic dout_o,
  output logic dout_oe_o,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_o,
  output logic track_o,
  output ctrl_t ctrl_byte_o,
  output logic ctrl_valid_o,
  output power_t power_o
);
  // Pin synchronisers hold {sclk, select, data}; only the second stage reads the first.
  logic [2:0] sclk_s1_r, sclk_s2_r;
  logic [1:0] shutdown_level_in_s1_r, shutdown_level_in_s2_r;
  logic sclk_s3_r, sclk_rise, sclk_fall, cs_low, din_sync, fifo_valid, fifo_pop;
  tx_state_t tx_state_r, tx_state_nxt;
  logic rx_active_r, rx_active_nxt, hold_pending_r, hold_pending_nxt, int_mode_r, int_mode_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt, out_cnt_r, out_cnt_nxt;
  logic [`CTRL_WIDTH-1:0] rx_shift_r, rx_shift_nxt;
  logic [`RESULT_WIDTH-1:0] result_r, result_nxt;
  logic [`CONV_TIMER_WIDTH-1:0] timer_r, timer_nxt;
  logic dout_r, dout_nxt, dout_oe_r, dout_oe_nxt, strobe_r, strobe_nxt, strobe_oe_r, strobe_oe_nxt;
  logic track_r, track_nxt, ctrl_valid_r, ctrl_valid_nxt;
  ctrl_t ctrl_r, ctrl_nxt;
  power_t power_r, power_nxt;
  logic [`RESULT_WIDTH-1:0] fifo_data;
  sample_fifo #(.WIDTH(`RESULT_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(sample_valid_i),
    .in_data_i(sample_data_i),
    .in_ready_o(sample_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );
  // --------------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------------
  // Reset loads the idle pin levels, so no false select or clock edge follows reset.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sclk_s1_r <= 3'h2;
      sclk_s2_r <= 3'h2;
      sclk_s3_r <= 1'b0;
      shutdown_level_in_s1_r <= `SHUTDOWN_LEVEL_IN_LEVEL_HIGH;
      shutdown_level_in_s2_r <= `SHUTDOWN_LEVEL_IN_LEVEL_HIGH;
    end else begin
      sclk_s1_r <= {sclk_i, cs_n_i, din_i};
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r[2];
      shutdown_level_in_s1_r <= shutdown_level_in_i;
      shutdown_level_in_s2_r <= shutdown_level_in_s1_r;
    end
  end
  assign din_sync = sclk_s2_r[0];
  assign cs_low = ~sclk_s2_r[1];
  assign sclk_rise = sclk_s2_r[2] & ~sclk_s3_r;
  assign sclk_fall = ~sclk_s2_r[2] & sclk_s3_r;
  // --------------------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------------------
  always_comb begin
    tx_state_nxt = tx_state_r;
    rx_active_nxt = rx_active_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_shift_nxt = rx_shift_r;
    hold_pending_nxt = hold_pending_r;
    int_mode_nxt = int_mode_r;
    result_nxt = result_r;
    out_cnt_nxt = out_cnt_r;
    timer_nxt = timer_r;
    dout_nxt = dout_r;
    strobe_nxt = strobe_r;
    track_nxt = track_r;
    ctrl_nxt = ctrl_r;
    ctrl_valid_nxt = 1'b0;
    fifo_pop = 1'b0;
    power_nxt.powered_down = shutdown_level_in_s2_r == `SHUTDOWN_LEVEL_IN_LEVEL_LOW;
    power_nxt.internal_comp = shutdown_level_in_s2_r == `SHUTDOWN_LEVEL_IN_LEVEL_HIGH;
    if (power_nxt.powered_down || !cs_low) begin
      // Select high drops any partial byte and any running conversion.
      rx_active_nxt = 1'b0;
      rx_cnt_nxt = 4'h0;
      hold_pending_nxt = 1'b0;
      track_nxt = 1'b0;
      tx_state_nxt = TX_IDLE;
      dout_nxt = 1'b0;
      strobe_nxt = int_mode_r;
    end else begin
      // Receiver: the first one after select falls opens the byte.
      if (sclk_rise && tx_state_r != TX_CONVERT && !hold_pending_r) begin
        if (rx_active_r) begin
          rx_shift_nxt = {rx_shift_r[`CTRL_WIDTH-2:0], din_sync};
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          if (rx_cnt_r + 4'h1 == `HOLD_BIT) begin
            rx_active_nxt = 1'b0;
            hold_pending_nxt = 1'b1;
          end
        end else if (din_sync) begin
          rx_active_nxt = 1'b1;
          rx_shift_nxt = {{(`CTRL_WIDTH-1){1'b0}}, 1'b1};
          rx_cnt_nxt = 4'h1;
        end
      end
      if (sclk_fall) begin
        if (rx_active_r && rx_cnt_r == `TRACK_START_BIT) begin
          track_nxt = 1'b1;
        end
        if (hold_pending_r) begin
          // Hold: the sample leaves the FIFO and the conversion begins.
          hold_pending_nxt = 1'b0;
          track_nxt = 1'b0;
          ctrl_nxt = ctrl_t'(rx_shift_r);
          ctrl_valid_nxt = 1'b1;
          int_mode_nxt = rx_shift_r[`CTRL_INT_CLK_BIT];
          fifo_pop = fifo_valid;
          result_nxt = fifo_valid ? fifo_data : '0;
          dout_nxt = 1'b0;
          if (rx_shift_r[`CTRL_INT_CLK_BIT]) begin
            strobe_nxt = 1'b0;
            timer_nxt = `CONV_TIMER_WIDTH'(`CONV_CYCLES - 1);
            tx_state_nxt = TX_CONVERT;
          end else begin
            strobe_nxt = 1'b1;
            tx_state_nxt = TX_STROBE;
          end
        end else if (tx_state_r == TX_STROBE) begin
          // The MSB decision follows one serial period of strobe.
          strobe_nxt = 1'b0;
          dout_nxt = result_r[`RESULT_MSB_INDEX];
          out_cnt_nxt = `RESULT_MSB_INDEX;
          tx_state_nxt = TX_SHIFT;
        end else if (tx_state_r == TX_SHIFT) begin
          if (out_cnt_r != 4'h0) begin
            dout_nxt = result_r[out_cnt_r - 4'h1];
            out_cnt_nxt = out_cnt_r - 4'h1;
          end else begin
            dout_nxt = 1'b0;
            tx_state_nxt = TX_IDLE;
          end
        end
      end
      if (tx_state_r == TX_CONVERT) begin
        if (timer_r == '0) begin
          // Internal clock finished: MSB is ready before the host's next rise.
          strobe_nxt = 1'b1;
          dout_nxt = result_r[`RESULT_MSB_INDEX];
          out_cnt_nxt = `RESULT_MSB_INDEX;
          tx_state_nxt = TX_SHIFT;
        end else begin
          timer_nxt = timer_r - `CONV_TIMER_WIDTH'(1);
        end
      end
    end
    dout_oe_nxt = cs_low;
    strobe_oe_nxt = int_mode_nxt | cs_low;
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_state_r <= TX_IDLE;
      rx_active_r <= 1'b0;
      rx_cnt_r <= 4'h0;
      rx_shift_r <= '0;
      hold_pending_r <= 1'b0;
      int_mode_r <= 1'b0;
      result_r <= '0;
      out_cnt_r <= 4'h0;
      timer_r <= '0;
      dout_r <= 1'b0;
      dout_oe_r <= 1'b0;
      strobe_r <= 1'b0;
      strobe_oe_r <= 1'b0;
      track_r <= 1'b0;
      ctrl_r <= '0;
      ctrl_valid_r <= 1'b0;
      power_r <= '0;
    end else begin
      tx_state_r <= tx_state_nxt;
      rx_active_r <= rx_active_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_shift_r <= rx_shift_nxt;
      hold_pending_r <= hold_pending_nxt;
      int_mode_r <= int_mode_nxt;
      result_r <= result_nxt;
      out_cnt_r <= out_cnt_nxt;
      timer_r <= timer_nxt;
      dout_r <= dout_nxt;
      dout_oe_r <= dout_oe_nxt;
      strobe_r <= strobe_nxt;
      strobe_oe_r <= strobe_oe_nxt;
      track_r <= track_nxt;
      ctrl_r <= ctrl_nxt;
      ctrl_valid_r <= ctrl_valid_nxt;
      power_r <= power_nxt;
    end
  end
  assign dout_o = dout_r;
  assign dout_oe_o = dout_oe_r;
  assign conversion_strobe_o = strobe_r;
  assign conversion_strobe_oe_o = strobe_oe_r;
  assign track_o = track_r;
  assign ctrl_byte_o = ctrl_r;
  assign ctrl_valid_o = ctrl_valid_r;
  assign power_o = power_r;
endmodule

// file: tb/serial_adc_pin_asserts.sv
// Checker for the serial converter pin interface.
`timescale 1ns/1ps
`include "adc_consts.svh"
module serial_adc_pin_asserts
  import adc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic [1:0] shutdown_level_in_i,
  input wire logic sample_valid_i,
  input wire logic [`RESULT_WIDTH-1:0] sample_data_i,
  input wire logic sample_ready_o,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe_o,
  input wire logic track_o,
  input wire ctrl_t ctrl_byte_o,
  input wire logic ctrl_valid_o,
  input wire power_t power_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [9:0] since_r;
  logic [9:0] since_nxt;
  // Cycles since the last control byte; saturates so it never wraps.
  always_comb begin
    since_nxt = since_r;
    if (ctrl_valid_o) begin
      since_nxt = 10'h0;
    end else if (since_r != 10'h3ff) begin
      since_nxt = since_r + 10'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    since_r <= reset_i ? 10'h0 : since_nxt;
  end
  chk_dout_on_fall: assert property ($changed(dout_o) |->
    !$past(sclk_i, 3) || !$past(sclk_i, 4) || !$past(sclk_i, 5)) else $error("dout moved");
  chk_dout_released: assert property (cs_n_i [*5] |-> !dout_oe_o)
    else $error("dout driven while deselected");
  chk_no_shift_idle: assert property (cs_n_i [*5] |-> !track_o && !ctrl_valid_o)
    else $error("activity while deselected");
  chk_int_conv_time: assert property ($rose(conversion_strobe_o) && ctrl_byte_o.int_clk
    && !cs_n_i |-> since_r inside {[10'h1f3:10'h1f5]}) else $error("conversion time wrong");
  chk_ext_strobe_width: assert property ($rose(conversion_strobe_o) && !ctrl_byte_o.int_clk
    |-> conversion_strobe_o [*8] ##1 !conversion_strobe_o) else $error("strobe width wrong");
  chk_strobe_released: assert property (cs_n_i [*5] ##0 !ctrl_byte_o.int_clk
    |-> !conversion_strobe_oe_o) else $error("strobe driven while deselected");
  chk_power_decode: assert property ($stable(shutdown_level_in_i) [*6] |->
    power_o == {shutdown_level_in_i == 2'h0, shutdown_level_in_i == 2'h3})
    else $error("power state wrong");
  chk_track_window: assert property (ctrl_valid_o |-> $fell(track_o)
    && $past(track_o, 24) && !$past(track_o, 25)) else $error("track window wrong");
  cover property ($rose(conversion_strobe_o) && ctrl_byte_o.int_clk);
  cover property (ctrl_valid_o && !ctrl_byte_o.int_clk);
  cover property ($fell(sample_ready_o));
endmodule

bind serial_adc_pin_interface serial_adc_pin_asserts u_serial_adc_pin_asserts (
  .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i),
  .shutdown_level_in_i(shutdown_level_in_i), .sample_valid_i(sample_valid_i),
  .sample_data_i(sample_data_i), .sample_ready_o(sample_ready_o), .dout_o(dout_o),
  .dout_oe_o(dout_oe_o), .conversion_strobe_o(conversion_strobe_o),
  .conversion_strobe_oe_o(conversion_strobe_oe_o), .track_o(track_o),
  .ctrl_byte_o(ctrl_byte_o), .ctrl_valid_o(ctrl_valid_o), .power_o(power_o));

// file: tb/spi_host_model.sv
// Serial host model: drives select, clock and data and gathers result bits.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic mclk_i,
  input wire logic miso_i,
  input wire logic strobe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Result is read just before the fall, well clear of the output's sync delay.
  task automatic pulse(input logic d, output logic q);
    din_o = d;
    wait_clk(4);
    sclk_o = 1'b1;
    wait_clk(4);
    q = miso_i;
    sclk_o = 1'b0;
  endtask
  task automatic frame(input int lead, input logic [7:0] c, input int nbits,
      output logic [11:0] res, output logic ok);
    logic q;
    int n;
    n = 0;
    ok = 1'b1;
    res = 12'h0;
    cs_n_o = 1'b0;
    wait_clk(8);
    repeat (lead) pulse(1'b0, q);
    for (int i = 7; i > 7 - nbits; i--) begin
      pulse(c[i], q);
    end
    if (nbits == 8) begin
      if (c[0]) begin
        wait_clk(8);
        while (!strobe_i && n < 800) begin
          wait_clk(1);
          n++;
        end
        ok = strobe_i;
      end else begin
        pulse(1'b0, q);
      end
      for (int i = 0; i < 12; i++) begin
        pulse(1'b0, q);
        res = {res[10:0], q};
      end
    end
    wait_clk(4);
    cs_n_o = 1'b1;
    wait_clk(8);
  endtask
endmodule

// file: tb/serial_adc_pin_interface_tb.sv
// Self-checking bench for the serial converter pin interface.
`timescale 1ns/1ps
`include "adc_consts.svh"
module serial_adc_pin_interface_tb;
  int err_count = 0;
  int cmp_count = 0;
  int pushed = 0;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] lvl = 2'h3;
  logic sv = 1'b0;
  logic [11:0] sd = 12'h0;
  logic sclk, cs_n, din, ready, dout, dout_oe, strb, strb_oe, track, cvalid, ok, hold;
  logic [7:0] cbyte;
  logic [1:0] pwr;
  logic [11:0] res;
  logic miso;
  logic strb_w;
  logic miso_last = 1'b0;
  logic strb_last = 1'b0;
  initial begin
    forever #10 mclk = ~mclk;
  end
  always_ff @(posedge mclk) begin
    miso_last <= miso;
    strb_last <= strb_w;
  end
  // A released line shows the inverse of its last level, so stale data cannot pass.
  assign miso = dout_oe ? dout : ~miso_last;
  assign strb_w = strb_oe ? strb : ~strb_last;
  serial_adc_pin_interface u_serial_adc_pin_interface (
    .mclk_i(mclk), .reset_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .shutdown_level_in_i(lvl), .sample_valid_i(sv), .sample_data_i(sd),
    .sample_ready_o(ready), .dout_o(dout), .dout_oe_o(dout_oe),
    .conversion_strobe_o(strb), .conversion_strobe_oe_o(strb_oe), .track_o(track),
    .ctrl_byte_o(cbyte), .ctrl_valid_o(cvalid), .power_o(pwr));
  spi_host_model u_spi_host_model (
    .mclk_i(mclk), .miso_i(miso), .strobe_i(strb_w), .sclk_o(sclk), .cs_n_o(cs_n),
    .din_o(din));
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic conv(input int lead, input logic [7:0] c, input logic [11:0] exp);
    u_spi_host_model.frame(lead, c, 8, res, ok);
    check("strobe wait", {11'h0, ok}, 12'h1);
    check("result", res, exp);
    check("control byte", {4'h0, cbyte}, {4'h0, c});
  endtask
  initial begin
    #1000000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    @(posedge mclk);
    #1;
    check("dout enable", {11'h0, dout_oe}, 12'h0);
    for (int i = 0; i < 4; i++) begin
      lvl = 2'(i);
      repeat (8) @(posedge mclk);
      #1;
      check("power", {10'h0, pwr}, {10'h0, i == 0, i == 3});
    end
    for (int i = 0; i < 20; i++) begin
      sd = 12'ha00 + 12'(pushed);
      sv = 1'b1;
      hold = ready;
      @(posedge mclk);
      #1;
      pushed += int'(hold);
    end
    sv = 1'b0;
    check("fill count", 12'(pushed), 12'h010);
    check("ready when full", {11'h0, ready}, 12'h0);
    conv(3, 8'hd4, 12'ha00);
    conv(0, 8'h8f, 12'ha01);
    check("strobe idle level", {11'h0, strb_w}, 12'h1);
    u_spi_host_model.frame(0, 8'hff, 5, res, ok);
    check("track after abort", {11'h0, track}, 12'h0);
    conv(2, 8'h94, 12'ha02);
    repeat (4) u_spi_host_model.pulse(1'b1, hold);
    check("byte kept", {4'h0, cbyte}, 12'h094);
    check("dout enable", {11'h0, dout_oe}, 12'h0);
    check("strobe enable", {11'h0, strb_oe}, 12'h0);
    check("ready after pop", {11'h0, ready}, 12'h1);
    for (int i = 3; i < 16; i++) begin
      conv(0, 8'h8e, 12'ha00 + 12'(i));
    end
    conv(1, 8'h8e, 12'h000);
    give_verdict();
  end
endmodule
